// ---- rtl/uirs_pkg.sv ----
// shared constants and carrier types for the uart/ir status register block
package uirs_pkg;
    // register word indices; byte address is index * 4
    localparam logic [3:0] IDX_MODEM_CTRL = 4'h4;
    localparam logic [3:0] IDX_LINK_STAT  = 4'h5;
    localparam logic [3:0] IDX_MODEM_STAT = 4'h6;
    localparam logic [3:0] IDX_SCRATCH    = 4'h7;
    localparam logic [3:0] IDX_CONFIG     = 4'h8;
    localparam logic [3:0] IDX_SOFT_RST   = 4'h9;
    // reset values, and the modem status view shown while masked
    localparam logic [7:0] LINK_STAT_RST  = 8'h60;
    localparam logic [7:0] MODEM_MASKED   = 8'h30;
    localparam logic [7:0] BYTE_ZERO      = 8'h00;
    // op_mode_select codes
    localparam logic [2:0] MODE_UART      = 3'h0;
    localparam logic [2:0] MODE_SHIFT_IR  = 3'h2;
    localparam logic [2:0] MODE_SIR       = 3'h3;
    localparam logic [2:0] MODE_MIR       = 3'h4;
    localparam logic [2:0] MODE_FIR       = 3'h5;
    localparam logic [2:0] MODE_CIR       = 3'h6;
    // field positions
    localparam int MCR_DTR = 0;
    localparam int MCR_RTS = 1;
    localparam int MCR_RIL = 2;
    localparam int MCR_DCL = 3;
    localparam int MCR_LOOP = 4;
    localparam int MCR_MODE_LSB = 5;
    localparam int CFG_EXT = 0;
    localparam int CFG_IRMASK = 1;
    localparam int CFG_STOPMD = 2;
    localparam int CFG_MSIE = 3;
    localparam int CFG_FIFO = 4;
    localparam int SRST_TX = 0;
    localparam int SRST_RX = 1;

    // status tags of the entry now at the receive fifo bottom
    typedef struct packed {
        logic frame_fault;
        logic line_break;
        logic phy_fault;
        logic too_long;
        logic frame_last;
    } uirs_rx_tag_s;

    // one character leaving the receive front end
    typedef struct packed {
        logic [7:0] data;
        logic       frame_fault;
        logic       line_break;
    } uirs_char_s;
endpackage : uirs_pkg

// ---- rtl/uirs_status_regs.sv ----
// status, modem-status and auxiliary registers of the uart/ir module
//
// Design decision made here: register access over Wishbone.
`timescale 1ns/1ps
module uirs_status_regs #(
    parameter int CHAR_BITS = 8
) (
    // clock, reset, enable
    input  wire logic                  mclk_in,
    input  wire logic                  sys_rst_in,
    input  wire logic                  ce_in,
    // wishbone slave
    input  wire logic                  wb_cyc_in,
    input  wire logic                  wb_stb_in,
    input  wire logic                  wb_we_in,
    input  wire logic [5:0]            wb_adr_in,
    input  wire logic [3:0]            wb_sel_in,
    input  wire logic [31:0]           wb_dat_in,
    output logic      [31:0]           wb_dat_out,
    output logic                       wb_ack_out,
    // modem pins, active low
    input  wire logic                  cts_n_in,
    input  wire logic                  dsr_n_in,
    input  wire logic                  ri_n_in,
    input  wire logic                  dcd_n_in,
    // receive bit sampler and fifo
    input  wire logic                  rx_bit_stb_in,
    input  wire logic                  rx_bit_in,
    input  wire logic                  rx_bottom_stb_in,
    input  wire uirs_pkg::uirs_rx_tag_s rx_bottom_tag_in,
    input  wire logic                  rx_fifo_err_in,
    input  wire logic                  rx_data_avail_in,
    input  wire logic                  rx_fifo_timeout_in,
    input  wire logic                  rx_char_read_in,
    input  wire logic                  frame_end_in_fifo_in,
    // transmit side
    input  wire logic                  tx_hold_empty_in,
    input  wire logic                  tx_front_idle_in,
    input  wire logic                  tx_data_write_in,
    input  wire logic                  tx_len_zero_in,
    // outputs
    output uirs_pkg::uirs_char_s       rx_char_out,
    output logic                       rx_char_valid_out,
    output logic                       modem_line_event_out,
    output logic                       end_transmission_req_out,
    output logic                       tx_halted_frame_end_out,
    output logic      [2:0]            op_mode_select_out
);
    if (CHAR_BITS < 5 || CHAR_BITS > 8) begin : g_char_bits_check
        $error("CHAR_BITS must be 5..8");
    end

    typedef enum logic [1:0] {FE_IDLE, FE_DATA, FE_STOP, FE_WAIT_ONE} uirs_fe_e;

    function automatic logic is_frame_mode(input logic [2:0] m);
        is_frame_mode = (m == uirs_pkg::MODE_MIR) || (m == uirs_pkg::MODE_FIR);
    endfunction : is_frame_mode

    function automatic logic is_char_mode(input logic [2:0] m);
        is_char_mode = (m == uirs_pkg::MODE_UART) || (m == uirs_pkg::MODE_SHIFT_IR)
                    || (m == uirs_pkg::MODE_SIR);
    endfunction : is_char_mode

    // modem pin synchronisers
    logic [3:0] pin_meta_r;
    logic [3:0] pin_sync_r;
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pin_meta_r <= 4'hF;
            pin_sync_r <= 4'hF;
        end else if (ce_in) begin
            pin_meta_r <= {dcd_n_in, ri_n_in, dsr_n_in, cts_n_in};
            pin_sync_r <= pin_meta_r;
        end
    end

    // state
    logic [7:0]  mcr_r, mcr_nxt, cfg_r, cfg_nxt, scratch_r, scratch_nxt;
    logic [7:0]  lsr_r, lsr_nxt, msr_r, msr_nxt, aux_r, aux_nxt;
    logic        ack_r, ack_nxt, event_r, event_nxt;
    logic [31:0] dat_r, dat_nxt;
    uirs_fe_e    fe_st_r, fe_st_nxt;
    logic [3:0]  fe_cnt_r, fe_cnt_nxt;
    logic [7:0]  fe_sh_r, fe_sh_nxt;
    logic        fe_zero_r, fe_zero_nxt;
    uirs_pkg::uirs_char_s ch_r, ch_nxt;
    logic        ch_v_r, ch_v_nxt;

    logic        req, wr, rd, wr_lane;
    logic [3:0]  idx;
    logic [2:0]  mode;
    logic        ext, fifo_on, mode_chg, tx_srst, rx_srst, rd_lsr, rd_msr;
    logic [3:0]  act_lvl, delta;
    logic [7:0]  msr_view;

    always_comb begin
        req      = wb_cyc_in && wb_stb_in && !ack_r;
        wr       = req && wb_we_in;
        rd       = req && !wb_we_in;
        wr_lane  = wr && wb_sel_in[0];
        idx      = wb_adr_in[5:2];
        mode     = mcr_r[7:5];
        ext      = cfg_r[uirs_pkg::CFG_EXT];
        fifo_on  = cfg_r[uirs_pkg::CFG_FIFO];
        mode_chg = wr_lane && idx == uirs_pkg::IDX_MODEM_CTRL
                && wb_dat_in[7:5] != mode;
        tx_srst  = wr_lane && idx == uirs_pkg::IDX_SOFT_RST && wb_dat_in[uirs_pkg::SRST_TX];
        rx_srst  = wr_lane && idx == uirs_pkg::IDX_SOFT_RST && wb_dat_in[uirs_pkg::SRST_RX];
        rd_lsr   = rd && idx == uirs_pkg::IDX_LINK_STAT;
        rd_msr   = rd && idx == uirs_pkg::IDX_MODEM_STAT;
        // active levels {dcd, ri, dsr, cts}; loopback ignores the pins
        if (mcr_r[uirs_pkg::MCR_LOOP]) begin
            if (ext) begin
                act_lvl = {mcr_r[uirs_pkg::MCR_RTS], mcr_r[uirs_pkg::MCR_DTR],
                           mcr_r[uirs_pkg::MCR_DTR], mcr_r[uirs_pkg::MCR_RTS]};
            end else begin
                act_lvl = {mcr_r[uirs_pkg::MCR_DCL], mcr_r[uirs_pkg::MCR_RIL],
                           mcr_r[uirs_pkg::MCR_DTR], mcr_r[uirs_pkg::MCR_RTS]};
            end
        end else begin
            act_lvl = ~pin_sync_r;
        end
        // ring counts only the pin going low to high, i.e. active to inactive
        delta = {act_lvl[3] ^ msr_r[7], msr_r[6] & ~act_lvl[2],
                 act_lvl[1] ^ msr_r[5], act_lvl[0] ^ msr_r[4]};
        if (mode != uirs_pkg::MODE_UART && cfg_r[uirs_pkg::CFG_IRMASK]) begin
            msr_view = uirs_pkg::MODEM_MASKED;
        end else begin
            msr_view = msr_r;
        end
    end

    // receive front end: start, data, stop; break and resync handling
    always_comb begin
        fe_st_nxt   = fe_st_r;
        fe_cnt_nxt  = fe_cnt_r;
        fe_sh_nxt   = fe_sh_r;
        fe_zero_nxt = fe_zero_r;
        ch_nxt      = ch_r;
        ch_v_nxt    = 1'b0;
        if (rx_bit_stb_in) begin
            unique case (fe_st_r)
                FE_IDLE: begin
                    if (!rx_bit_in) begin
                        fe_st_nxt   = FE_DATA;
                        fe_cnt_nxt  = 4'h0;
                        fe_zero_nxt = 1'b1;
                    end
                end
                FE_DATA: begin
                    fe_sh_nxt   = {rx_bit_in, fe_sh_r[7:1]};
                    fe_zero_nxt = fe_zero_r && !rx_bit_in;
                    fe_cnt_nxt  = fe_cnt_r + 4'h1;
                    if (fe_cnt_r == 4'(CHAR_BITS - 1)) begin
                        fe_st_nxt = FE_STOP;
                    end
                end
                FE_STOP: begin
                    ch_v_nxt = 1'b1;
                    ch_nxt.data = fe_sh_r >> (8 - CHAR_BITS);
                    ch_nxt.frame_fault = !rx_bit_in;
                    ch_nxt.line_break  = !rx_bit_in && fe_zero_r;
                    if (!rx_bit_in && fe_zero_r) begin
                        ch_nxt.data = uirs_pkg::BYTE_ZERO;
                        fe_st_nxt   = FE_WAIT_ONE;
                    end else begin
                        // a zero right after a bad stop bit is taken as a start
                        fe_st_nxt = FE_IDLE;
                    end
                end
                FE_WAIT_ONE: begin
                    if (rx_bit_in) begin
                        fe_st_nxt = FE_IDLE;
                    end
                end
            endcase
        end
        if (rx_srst) begin
            fe_st_nxt = FE_IDLE;
        end
    end

    // register file and status flags
    always_comb begin
        logic frame_md, char_md, clr_link;
        frame_md    = is_frame_mode(mode);
        char_md     = is_char_mode(mode);
        mcr_nxt     = mcr_r;
        cfg_nxt     = cfg_r;
        scratch_nxt = scratch_r;
        ack_nxt     = req;
        dat_nxt     = '0;
        clr_link    = rd_lsr || rx_srst;
        // link status: clear first, then sets, so an event never gets lost
        lsr_nxt     = lsr_r;
        lsr_nxt[0]  = rx_data_avail_in;
        if (clr_link) begin
            lsr_nxt[4:3] = 2'h0;
            lsr_nxt[7]   = 1'b0;
        end
        if (char_md) begin
            if (fifo_on && rx_bottom_stb_in) begin
                lsr_nxt[3] = lsr_nxt[3] | rx_bottom_tag_in.frame_fault;
                lsr_nxt[4] = lsr_nxt[4] | rx_bottom_tag_in.line_break;
            end
            if (!fifo_on && ch_v_r) begin
                lsr_nxt[3] = lsr_nxt[3] | ch_r.frame_fault;
                lsr_nxt[4] = lsr_nxt[4] | ch_r.line_break;
            end
            if (fifo_on && rx_fifo_err_in) begin
                lsr_nxt[7] = 1'b1;
            end
        end
        if (frame_md && rx_bottom_stb_in && rx_bottom_tag_in.frame_last) begin
            lsr_nxt[3] = lsr_nxt[3] | rx_bottom_tag_in.phy_fault;
            lsr_nxt[4] = lsr_nxt[4] | rx_bottom_tag_in.too_long;
            lsr_nxt[7] = 1'b1;
        end
        if (tx_hold_empty_in) begin
            lsr_nxt[5] = 1'b1;
        end else if (tx_data_write_in) begin
            lsr_nxt[5] = 1'b0;
        end
        lsr_nxt[6] = tx_hold_empty_in && tx_front_idle_in;
        // modem status
        msr_nxt = {act_lvl, msr_r[3:0]};
        if (rd_msr || (mode_chg && !cfg_r[uirs_pkg::CFG_IRMASK])) begin
            msr_nxt[3:0] = 4'h0;
        end
        msr_nxt[3:0] = msr_nxt[3:0] | delta;
        event_nxt = (|msr_r[3:0]) && cfg_r[uirs_pkg::CFG_MSIE];
        // auxiliary status and control
        aux_nxt = aux_r;
        aux_nxt[1] = frame_md && frame_end_in_fifo_in;
        if (rx_char_read_in) begin
            aux_nxt[0] = 1'b0;
        end
        if (rx_fifo_timeout_in) begin
            aux_nxt[0] = 1'b1;
        end
        if (tx_data_write_in) begin
            aux_nxt[2] = 1'b0;
        end
        if (wr_lane && ext && idx == uirs_pkg::IDX_SCRATCH) begin
            if (wb_dat_in[2] && (frame_md || mode == uirs_pkg::MODE_CIR)) begin
                aux_nxt[2] = 1'b1;
            end
            if (wb_dat_in[3]) begin
                aux_nxt[3] = 1'b0;
            end
        end
        if (frame_md && cfg_r[uirs_pkg::CFG_STOPMD] && tx_len_zero_in) begin
            aux_nxt[3] = 1'b1;
        end
        if (tx_srst) begin
            aux_nxt[2] = 1'b0;
            aux_nxt[6] = 1'b0;
        end
        if (rx_srst) begin
            aux_nxt[1:0] = 2'h0;
            aux_nxt[5:4] = 2'h0;
        end
        if (mode_chg) begin
            aux_nxt = '0;
        end
        // bus writes
        if (wr_lane) begin
            unique case (idx)
                uirs_pkg::IDX_MODEM_CTRL: mcr_nxt = wb_dat_in[7:0];
                uirs_pkg::IDX_CONFIG:     cfg_nxt = wb_dat_in[7:0];
                uirs_pkg::IDX_SCRATCH:    if (!ext) scratch_nxt = wb_dat_in[7:0];
                default: ;
            endcase
        end
        // bus reads; unmapped words answer zero
        if (rd) begin
            unique case (idx)
                uirs_pkg::IDX_MODEM_CTRL: dat_nxt[7:0] = mcr_r;
                uirs_pkg::IDX_LINK_STAT:  dat_nxt[7:0] = lsr_r;
                uirs_pkg::IDX_MODEM_STAT: dat_nxt[7:0] = msr_view;
                uirs_pkg::IDX_SCRATCH:    dat_nxt[7:0] = ext ? aux_r : scratch_r;
                uirs_pkg::IDX_CONFIG:     dat_nxt[7:0] = cfg_r;
                default:                  dat_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            mcr_r     <= uirs_pkg::BYTE_ZERO;
            cfg_r     <= uirs_pkg::BYTE_ZERO;
            scratch_r <= uirs_pkg::BYTE_ZERO;
            lsr_r     <= uirs_pkg::LINK_STAT_RST;
            msr_r     <= uirs_pkg::BYTE_ZERO;
            aux_r     <= uirs_pkg::BYTE_ZERO;
            ack_r     <= 1'b0;
            event_r   <= 1'b0;
            dat_r     <= '0;
            fe_st_r   <= FE_IDLE;
            fe_cnt_r  <= 4'h0;
            fe_sh_r   <= uirs_pkg::BYTE_ZERO;
            fe_zero_r <= 1'b0;
            ch_r      <= '0;
            ch_v_r    <= 1'b0;
        end else if (ce_in) begin
            mcr_r     <= mcr_nxt;
            cfg_r     <= cfg_nxt;
            scratch_r <= scratch_nxt;
            lsr_r     <= lsr_nxt;
            msr_r     <= msr_nxt;
            aux_r     <= aux_nxt;
            ack_r     <= ack_nxt;
            event_r   <= event_nxt;
            dat_r     <= dat_nxt;
            fe_st_r   <= fe_st_nxt;
            fe_cnt_r  <= fe_cnt_nxt;
            fe_sh_r   <= fe_sh_nxt;
            fe_zero_r <= fe_zero_nxt;
            ch_r      <= ch_nxt;
            ch_v_r    <= ch_v_nxt;
        end
    end

    assign wb_dat_out               = dat_r;
    assign wb_ack_out               = ack_r;
    assign rx_char_out              = ch_r;
    assign rx_char_valid_out        = ch_v_r;
    assign modem_line_event_out     = event_r;
    assign end_transmission_req_out = aux_r[2];
    assign tx_halted_frame_end_out  = aux_r[3];
    assign op_mode_select_out       = mcr_r[7:5];
endmodule : uirs_status_regs

// ---- tb/test_uart_ir_status_regs.sv ----
// self-checking bench for the uart/ir status register block
`timescale 1ns/1ps
module test_uart_ir_status_regs;
    logic        mclk_in = 1'b0, sys_rst_in = 1'b1, ce_in = 1'b1;
    logic        wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0, wb_ack_out;
    logic [5:0]  wb_adr_in = 6'h00;
    logic [3:0]  wb_sel_in = 4'h0;
    logic [31:0] wb_dat_in = 32'h0, wb_dat_out, rd;
    logic        cts_n_in, dsr_n_in, ri_n_in, dcd_n_in, rx_bit_stb_in, rx_bit_in;
    logic        rx_fifo_err_in = 1'b0, rx_data_avail_in = 1'b0, frame_end_in_fifo_in = 1'b0;
    logic        tx_hold_empty_in = 1'b1, tx_front_idle_in = 1'b1;
    logic        rx_char_valid_out, modem_line_event_out, end_transmission_req_out;
    logic        tx_halted_frame_end_out;
    logic [2:0]  op_mode_select_out;
    // pulses: 0 tx write, 1 rx timeout, 2 rx char read, 3 length zero, 4 fifo bottom
    logic [4:0]  pls = 5'h00;
    uirs_pkg::uirs_rx_tag_s rx_bottom_tag_in = '0;
    uirs_pkg::uirs_char_s   rx_char_out, last_char;
    int          n_mismatch = 0, total_checks = 0, n_chars = 0;
    always #12.5 mclk_in = ~mclk_in;
    uirs_status_regs u_uirs_status_regs (.mclk_in, .sys_rst_in, .ce_in, .wb_cyc_in,
        .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out,
        .cts_n_in, .dsr_n_in, .ri_n_in, .dcd_n_in, .rx_bit_stb_in, .rx_bit_in,
        .rx_bottom_stb_in(pls[4]), .rx_bottom_tag_in, .rx_fifo_err_in, .rx_data_avail_in,
        .rx_fifo_timeout_in(pls[1]), .rx_char_read_in(pls[2]), .frame_end_in_fifo_in,
        .tx_hold_empty_in, .tx_front_idle_in, .tx_data_write_in(pls[0]),
        .tx_len_zero_in(pls[3]), .rx_char_out, .rx_char_valid_out, .modem_line_event_out,
        .end_transmission_req_out, .tx_halted_frame_end_out, .op_mode_select_out);
    uirs_modem_model u_uirs_modem_model (.mclk_in, .cts_n_out(cts_n_in),
        .dsr_n_out(dsr_n_in), .ri_n_out(ri_n_in), .dcd_n_out(dcd_n_in),
        .bit_stb_out(rx_bit_stb_in), .bit_out(rx_bit_in));
    always @(posedge mclk_in) begin
        if (rx_char_valid_out === 1'b1) begin
            last_char <= rx_char_out;
            n_chars   <= n_chars + 1;
        end
    end
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : final_report
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // one classic cycle; the answer time is the slave's, bounded only by our limit
    task automatic wb(input logic we, input logic [3:0] idx, input logic [7:0] d,
                      input logic s0 = 1'b1);
        int k;
        @(posedge mclk_in);
        {wb_cyc_in, wb_stb_in, wb_we_in} <= {2'b11, we};
        wb_adr_in <= {idx, 2'b00};
        wb_sel_in <= {3'h0, s0};
        wb_dat_in <= {24'h0, d};
        k = 0;
        do begin
            @(posedge mclk_in);
            k++;
        end while (wb_ack_out !== 1'b1 && k < 50);
        rd = wb_dat_out;
        {wb_cyc_in, wb_stb_in} <= 2'b00;
        if (k >= 50) begin
            n_mismatch++;
            final_report();
        end
    endtask : wb
    task automatic rd_chk(input logic [3:0] idx, input logic [7:0] exp, input string what);
        wb(1'b0, idx, 8'h00);
        chk(what, {24'h0, exp}, rd);
    endtask : rd_chk
    task automatic pulse(input logic [4:0] m);
        @(posedge mclk_in);
        pls <= m;
        @(posedge mclk_in);
        pls <= 5'h00;
    endtask : pulse
    task automatic t_basic;
        rd_chk(4'h5, 8'h60, "link status reset");
        wb(1'b1, 4'h7, 8'hA5);
        wb(1'b1, 4'h7, 8'h5A, 1'b0);
        rd_chk(4'h7, 8'hA5, "scratch");
        rd_chk(4'hF, 8'h00, "unmapped");
    endtask : t_basic
    task automatic t_tx;
        tx_front_idle_in <= 1'b0;
        rd_chk(4'h5, 8'h20, "ready not empty");
        tx_hold_empty_in <= 1'b0;
        pulse(5'h01);
        rd_chk(4'h5, 8'h00, "ready after write");
        {tx_hold_empty_in, tx_front_idle_in} <= 2'b11;
        rd_chk(4'h5, 8'h60, "both idle");
    endtask : t_tx
    task automatic t_frame;
        u_uirs_modem_model.send_bits({10'h3FF, 1'b1, 8'h3C, 2'b00, 8'h55, 1'b0}, 0);
        chk("char after fault", {22'h0, 8'h3C, 2'b00}, {22'h0, last_char});
        rd_chk(4'h5, 8'h68, "frame fault");
        rd_chk(4'h5, 8'h60, "fault cleared");
    endtask : t_frame
    task automatic t_break;
        int n0;
        n0 = n_chars;
        u_uirs_modem_model.send_bits({6'h3F, 1'b1, 8'h81, 1'b0, 1'b1, 13'h0000}, 3);
        chk("break char count", n0 + 2, n_chars);
        chk("char after break", {22'h0, 8'h81, 2'b00}, {22'h0, last_char});
        // the all-zero stop bit of a break also counts as a framing fault
        rd_chk(4'h5, 8'h78, "break flag");
    endtask : t_break
    task automatic t_fifo;
        wb(1'b1, 4'h8, 8'h10);
        rx_fifo_err_in   <= 1'b1;
        rx_bottom_tag_in <= 5'b10000;
        pulse(5'h10);
        rd_chk(4'h5, 8'hE8, "fault at bottom");
        rx_fifo_err_in <= 1'b0;
        rd_chk(4'h5, 8'hE0, "fifo error pending");
        for (int m = 4; m < 6; m++) begin
            wb(1'b1, 4'h4, {m[2:0], 5'h00});
            chk("mode output", m, {29'h0, op_mode_select_out});
            rx_bottom_tag_in <= 5'b00111;
            pulse(5'h10);
            rd_chk(4'h5, 8'hF8, "frame flags");
        end
        wb(1'b1, 4'h4, 8'h00);
        wb(1'b1, 4'h8, 8'h00);
    endtask : t_fifo
    task automatic lines(input logic [3:0] v);
        u_uirs_modem_model.set_lines(v);
        repeat (6) @(posedge mclk_in);
    endtask : lines
    task automatic t_modem;
        wb(1'b1, 4'h8, 8'h08);
        wb(1'b0, 4'h6, 8'h00);
        lines(4'b0111);
        chk("modem event", 32'h1, {31'h0, modem_line_event_out});
        rd_chk(4'h6, 8'h11, "cts change");
        repeat (2) @(posedge mclk_in);
        chk("event after read", 32'h0, {31'h0, modem_line_event_out});
        lines(4'b0101);
        rd_chk(4'h6, 8'h50, "ring falls");
        lines(4'b0111);
        rd_chk(4'h6, 8'h14, "ring trailing");
        wb(1'b1, 4'h4, 8'h12);
        wb(1'b0, 4'h6, 8'h00);
        lines(4'b0000);
        rd_chk(4'h6, 8'h10, "loop ignores pins");
        wb(1'b1, 4'h4, 8'h13);
        repeat (6) @(posedge mclk_in);
        rd_chk(4'h6, 8'h32, "loop dsr");
        wb(1'b1, 4'h8, 8'h0B);
        wb(1'b1, 4'h4, 8'h60);
        rd_chk(4'h6, 8'h30, "masked ir");
        wb(1'b1, 4'h8, 8'h00);
        wb(1'b1, 4'h4, 8'h00);
    endtask : t_modem
    task automatic t_aux;
        wb(1'b1, 4'h8, 8'h05);
        wb(1'b1, 4'h4, 8'h80);
        frame_end_in_fifo_in <= 1'b1;
        pulse(5'h02);
        wb(1'b1, 4'h7, 8'h04);
        chk("end request set", 32'h1, {31'h0, end_transmission_req_out});
        pulse(5'h08);
        rd_chk(4'h7, 8'h0F, "aux all set");
        pulse(5'h05);
        frame_end_in_fifo_in <= 1'b0;
        rd_chk(4'h7, 8'h08, "aux after writes");
        chk("end request out", 32'h0, {31'h0, end_transmission_req_out});
        wb(1'b1, 4'h7, 8'h08);
        chk("halt cleared", 32'h0, {31'h0, tx_halted_frame_end_out});
        pulse(5'h0A);
        wb(1'b1, 4'h7, 8'h04);
        wb(1'b1, 4'h9, 8'h01);
        rd_chk(4'h7, 8'h09, "tx soft reset");
        wb(1'b1, 4'h9, 8'h02);
        rd_chk(4'h7, 8'h08, "rx soft reset");
        wb(1'b1, 4'h4, 8'hA0);
        rd_chk(4'h7, 8'h00, "mode change");
    endtask : t_aux
    initial begin
        repeat (20) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        t_basic();
        t_tx();
        t_frame();
        t_break();
        t_fifo();
        t_modem();
        t_aux();
        final_report();
    end
    initial begin
        repeat (20000) @(posedge mclk_in);
        n_mismatch++;
        final_report();
    end
endmodule : test_uart_ir_status_regs

// ---- tb/uirs_modem_model.sv ----
// behavioural modem pins and serial bit source facing the status block
`timescale 1ns/1ps
module uirs_modem_model (
    // clock
    input  wire logic mclk_in,
    // modem pins, active low, order cts dsr ri dcd
    output logic      cts_n_out,
    output logic      dsr_n_out,
    output logic      ri_n_out,
    output logic      dcd_n_out,
    // sampled serial bits
    output logic      bit_stb_out,
    output logic      bit_out
);
    initial begin
        {cts_n_out, dsr_n_out, ri_n_out, dcd_n_out} = 4'hF;
        bit_stb_out = 1'b0;
        bit_out     = 1'b1;
    end
    task automatic set_lines(input logic [3:0] v);
        @(posedge mclk_in);
        {cts_n_out, dsr_n_out, ri_n_out, dcd_n_out} <= v;
    endtask : set_lines
    // lsb first; gap makes the far end slow; between strobes the line shows garbage
    task automatic send_bits(input logic [29:0] v, input int gap);
        for (int i = 0; i < 30; i++) begin
            @(posedge mclk_in);
            bit_stb_out <= 1'b1;
            bit_out     <= v[i];
            @(posedge mclk_in);
            bit_stb_out <= 1'b0;
            bit_out     <= ~v[i];
            repeat (gap) @(posedge mclk_in);
        end
    endtask : send_bits
endmodule : uirs_modem_model

// ---- tb/uirs_status_regs_assertions.sv ----
// concurrent checks on the status register block ports
`timescale 1ns/1ps
module uirs_status_regs_checker #(
    parameter int CHAR_BITS = 8
) (
    // clock, reset, bus
    input wire logic                 mclk_in,
    input wire logic                 sys_rst_in,
    input wire logic                 ce_in,
    input wire logic                 wb_cyc_in,
    input wire logic                 wb_stb_in,
    input wire logic                 wb_we_in,
    input wire logic [5:0]           wb_adr_in,
    input wire logic [3:0]           wb_sel_in,
    input wire logic [31:0]          wb_dat_in,
    input wire logic                 wb_ack_out,
    // link and transmit side
    input wire logic                 rx_bit_stb_in,
    input wire logic                 tx_data_write_in,
    input wire logic                 tx_len_zero_in,
    input wire logic                 rx_char_valid_out,
    input wire uirs_pkg::uirs_char_s rx_char_out,
    input wire logic                 end_transmission_req_out,
    input wire logic                 tx_halted_frame_end_out,
    input wire logic [2:0]           op_mode_select_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);
    logic       take;
    logic       wr;
    logic       wr_or_txw;
    logic [2:0] mode_wr;
    assign take      = wb_cyc_in && wb_stb_in && !wb_ack_out && ce_in;
    assign wr        = take && wb_we_in;
    assign wr_or_txw = wr || tx_data_write_in;
    assign mode_wr   = wb_dat_in[7:5];
    ack_after_take_a: assert property (take |=> wb_ack_out)
        else $error("ack missing one cycle after request");
    ack_one_cycle_a: assert property (wb_ack_out && ce_in |=> !wb_ack_out)
        else $error("ack held longer than one cycle");
    mode_follow_a: assert property (
        wr && wb_sel_in[0] && wb_adr_in[5:2] == uirs_pkg::IDX_MODEM_CTRL
        |=> op_mode_select_out == $past(mode_wr)) else $error("mode field not taken");
    endtx_clear_a: assert property (
        ce_in && tx_data_write_in && !(wr && wb_adr_in[5:2] == uirs_pkg::IDX_SCRATCH)
        |=> !end_transmission_req_out) else $error("end request kept after fifo write");
    endtx_hold_a: assert property (
        $fell(end_transmission_req_out) |-> $past(wr_or_txw))
        else $error("end request dropped without cause");
    halted_set_a: assert property (
        $rose(tx_halted_frame_end_out) |-> $past(tx_len_zero_in))
        else $error("halt flag rose without zero count");
    halted_hold_a: assert property (
        $fell(tx_halted_frame_end_out) |-> $past(wr)) else $error("halt flag lost");
    char_after_stop_a: assert property (
        rx_char_valid_out |-> $past(rx_bit_stb_in)) else $error("char without stop strobe");
    break_zero_a: assert property (
        rx_char_valid_out && rx_char_out.line_break |-> rx_char_out.data == 8'h00)
        else $error("break char not zero");
endmodule : uirs_status_regs_checker
bind uirs_status_regs uirs_status_regs_checker #(.CHAR_BITS(CHAR_BITS)) u_chk (.mclk_in,
    .sys_rst_in, .ce_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in,
    .wb_dat_in, .wb_ack_out, .rx_bit_stb_in, .tx_data_write_in, .tx_len_zero_in,
    .rx_char_valid_out, .rx_char_out, .end_transmission_req_out,
    .tx_halted_frame_end_out, .op_mode_select_out);
